// *** rtl/serial_receive_control_consts.vh ***
// Constants for the serial receive control block
// Assumes inclusion by bare name from rtl files
`ifndef SERIAL_RECEIVE_CONTROL_CONSTS_VH
`define SERIAL_RECEIVE_CONTROL_CONSTS_VH
`define RSC_ADDR_STATUS_CONTROL 12'h000
`define RSC_ADDR_MODE 12'h004
`define RSC_ADDR_STATE 12'h008
`define RSC_RESET_BYTE 8'h00
`define RSC_RESET_MODE 3'h0
`define RSC_BIT_PORT_EN 7
`define RSC_BIT_NINE_BIT 6
`define RSC_BIT_SINGLE 5
`define RSC_BIT_CONT 4
`define RSC_BIT_ADDR_DET 3
`define RSC_BIT_MODE_SYNC 0
`define RSC_BIT_MODE_MASTER 1
`define RSC_BIT_MODE_TX 2
`define RSC_WORD_BITS 4'h8
`define RSC_ZERO_COUNT 4'h0
`define RSC_WR_MASK 8'hf8
`endif

// *** rtl/serial_receive_control.v ***
// Receive-side control of a serial port with an APB register file
// Assumes an APB master on the same clock; data pin is asynchronous
// Behaviour
// - In synchronous mode a set continuous receive enable, or as master a set single receive enable, overrides transmit enable.
// - Single receive enable is ignored in asynchronous and synchronous slave modes.
// - As synchronous master, a single-word reception runs only while single receive is set.
// - As synchronous master with continuous receive clear, hardware clears single receive when that reception ends.
// - In asynchronous mode the receiver is active exactly while the port is enabled and continuous receive is set.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
`include "serial_receive_control_consts.vh"
module serial_receive_control (
   input wire clock,
   input wire srst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire data_pin_in,
   input wire clock_pin_in,
   output reg data_pin_out,
   output reg data_pin_oe,
   output reg clock_pin_out,
   output reg clock_pin_oe,
   output reg receiver_active,
   output reg transmit_active,
   output reg port_in_reset,
   output reg [7:0] received_word
);
   reg [7:0] ctrl_r;
   reg [2:0] mode_r;
   reg [1:0] data_sync_r;
   reg [1:0] clk_sync_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg single_busy_r;
   reg sclk_r;
   reg sclk_prev_r;
   wire apb_access = psel && penable && !pready;
   wire wr = apb_access && pwrite;
   wire port_en = ctrl_r[`RSC_BIT_PORT_EN];
   wire sync_mode = mode_r[`RSC_BIT_MODE_SYNC];
   wire master = mode_r[`RSC_BIT_MODE_MASTER];
   wire single_en = ctrl_r[`RSC_BIT_SINGLE] && sync_mode && master;
   wire cont_en = ctrl_r[`RSC_BIT_CONT];
   wire rx_req = cont_en || single_en;
   wire tx_allowed = mode_r[`RSC_BIT_MODE_TX] && !(sync_mode && rx_req);
   wire rx_on = port_en && rx_req;
   wire slave_edge = clk_sync_r[1] && !sclk_prev_r;
   wire master_edge = sclk_r;
   wire sample = sync_mode ? (master ? master_edge : slave_edge) : 1'b1;
   wire word_done = rx_on && sample && (bit_cnt_r == `RSC_WORD_BITS - 4'h1);
   reg [7:0] ctrl_nxt;
   function [31:0] rd_mux;
      input [11:0] a;
      input [7:0] c;
      input [2:0] m;
      input [7:0] w;
      begin
         case (a)
            `RSC_ADDR_STATUS_CONTROL: rd_mux = {24'h000000, c};
            `RSC_ADDR_MODE: rd_mux = {29'h00000000, m};
            `RSC_ADDR_STATE: rd_mux = {24'h000000, w};
            default: rd_mux = 32'h00000000;
         endcase
      end
   endfunction
   always @* begin
      ctrl_nxt = ctrl_r;
      if (wr && paddr == `RSC_ADDR_STATUS_CONTROL) begin
         ctrl_nxt = pwdata[7:0] & `RSC_WR_MASK;
      end
      // Hardware clear wins over a same-cycle software set
      if (word_done && single_en && !cont_en) begin
         ctrl_nxt[`RSC_BIT_SINGLE] = 1'b0;
      end
   end
   always @(posedge clock) begin
      if (srst) begin
         ctrl_r <= `RSC_RESET_BYTE;
         mode_r <= `RSC_RESET_MODE;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         pready <= apb_access;
         pslverr <= apb_access && paddr != `RSC_ADDR_STATUS_CONTROL &&
            paddr != `RSC_ADDR_MODE && paddr != `RSC_ADDR_STATE;
         if (wr && paddr == `RSC_ADDR_MODE) begin
            mode_r <= pwdata[2:0];
         end
         if (apb_access && !pwrite) begin
            prdata <= rd_mux(paddr, ctrl_r, mode_r, received_word);
         end
      end
   end
   always @(posedge clock) begin
      if (srst) begin
         data_sync_r <= 2'h0;
         clk_sync_r <= 2'h0;
         sclk_prev_r <= 1'b0;
      end else begin
         data_sync_r <= {data_sync_r[0], data_pin_in};
         clk_sync_r <= {clk_sync_r[0], clock_pin_in};
         sclk_prev_r <= clk_sync_r[1];
      end
   end
   // Serial side held in reset while the port is disabled
   always @(posedge clock) begin
      if (srst || !port_en) begin
         bit_cnt_r <= `RSC_ZERO_COUNT;
         shift_r <= `RSC_RESET_BYTE;
         received_word <= `RSC_RESET_BYTE;
         single_busy_r <= 1'b0;
         sclk_r <= 1'b0;
         receiver_active <= 1'b0;
         transmit_active <= 1'b0;
         port_in_reset <= 1'b1;
         data_pin_out <= 1'b0;
         data_pin_oe <= 1'b0;
         clock_pin_out <= 1'b0;
         clock_pin_oe <= 1'b0;
      end else begin
         port_in_reset <= 1'b0;
         receiver_active <= rx_on;
         transmit_active <= tx_allowed;
         single_busy_r <= single_en && !cont_en && !word_done;
         // Master clock toggles each cycle; a simple half rate stands in for baud
         sclk_r <= (sync_mode && master && rx_on) ? !sclk_r : 1'b0;
         clock_pin_out <= sclk_r;
         clock_pin_oe <= sync_mode && master;
         data_pin_out <= 1'b1;
         data_pin_oe <= tx_allowed;
         if (!rx_on) begin
            bit_cnt_r <= `RSC_ZERO_COUNT;
         end else if (sample) begin
            shift_r <= {data_sync_r[1], shift_r[7:1]};
            if (word_done) begin
               bit_cnt_r <= `RSC_ZERO_COUNT;
               received_word <= {data_sync_r[1], shift_r[7:1]};
            end else begin
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end
         end
      end
   end
endmodule

// *** bench/serial_receive_control_asserts.sv ***
// Port checks for the serial receive control block
// Assumes one clock domain with synchronous reset srst
`timescale 1ns/1ns
module serial_receive_control_asserts (
   input wire clock, srst, psel, penable, pready, pslverr,
   input wire receiver_active, transmit_active, port_in_reset, data_pin_oe, clock_pin_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_acc; psel && penable && !pready; endsequence
   property p_rdy; s_acc |=> pready ##1 !pready; endproperty
   property p_rdy_src; pready |-> $past(psel && penable); endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_off_act; port_in_reset |-> !receiver_active && !transmit_active; endproperty
   property p_off_pin; port_in_reset |-> !data_pin_oe && !clock_pin_oe; endproperty
   property p_off_rise; $rose(port_in_reset) |=> !receiver_active [*2]; endproperty
   property p_tx_pin; data_pin_oe == transmit_active; endproperty
   a_rdy: assert property (p_rdy) else $error("ready late or long");
   a_rdy_src: assert property (p_rdy_src) else $error("ready without access");
   a_err: assert property (p_err) else $error("error without ready");
   a_off_act: assert property (p_off_act) else $error("active in reset");
   a_off_pin: assert property (p_off_pin) else $error("pins driven in reset");
   a_off_rise: assert property (p_off_rise) else $error("receiver after disable");
   a_tx_pin: assert property (p_tx_pin) else $error("data pin drive differs");
endmodule
bind serial_receive_control serial_receive_control_asserts chk_i (.clock, .srst, .psel,
   .penable, .pready, .pslverr, .receiver_active, .transmit_active, .port_in_reset,
   .data_pin_oe, .clock_pin_oe);

// *** bench/serial_peer_model.sv ***
// Serial peer: on go clocks one word out LSB first, four cycles a bit
// Clock rests low between frames; released data toggles so it is never stale
`timescale 1ns/1ns
module serial_peer_model (
   input wire clock, go,
   input wire [7:0] word,
   output logic data = 1'b0,
   output logic sclk = 1'b0
);
   logic [7:0] sh = 8'h00;
   int n = 0;
   always @(posedge clock) begin
      if (go) begin
         sh <= word;
         n <= 32;
      end else if (n > 0) begin
         n <= n - 1;
         data <= sh[(32 - n) / 4];
         sclk <= ((32 - n) % 4) >= 2;
      end else begin
         data <= ~data;
         sclk <= 1'b0;
      end
   end
endmodule

// *** bench/serial_receive_control_tb_top.sv ***
// Bench for the serial receive control block with a serial peer
// Assumes APB with one wait state; design inputs change on rising edges
`timescale 1ns/1ns
`include "serial_receive_control_consts.vh"
module serial_receive_control_tb_top;
   logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, r, s = 18;
   wire [31:0] prdata;
   wire [7:0] rw;
   wire pready, pslverr, rxa, txa, pir, pd, pc;
   int n_fail = 0, n_checks = 0;
   always #5 clock = ~clock;
   serial_receive_control dut (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .data_pin_in(pd), .clock_pin_in(pc), .data_pin_out(),
      .data_pin_oe(), .clock_pin_out(), .clock_pin_oe(), .receiver_active(rxa),
      .transmit_active(txa), .port_in_reset(pir), .received_word(rw));
   serial_peer_model peer (.clock, .go, .word(r[7:0]), .data(pd), .sclk(pc));
   function logic [31:0] xs;
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
   endtask
   task results;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard, far beyond the expected two thousand or so cycles
   initial begin
      #200000;
      n_fail++;
      results;
   end
   initial begin
      repeat (12) @(posedge clock);
      srst <= 0;
      @(posedge clock);
      chk(pir, 1);
      repeat (24) begin
         r = xs();
         apb(1, `RSC_ADDR_MODE, {29'h0, r[10:8]});
         apb(1, `RSC_ADDR_STATUS_CONTROL, {24'h0, r[7:0]});
         repeat (60) @(posedge clock);
         chk(rxa, r[7] & r[4]);
         chk(txa, r[7] & r[10] & !(r[8] & r[4]));
         chk(pir, !r[7]);
         apb(0, `RSC_ADDR_STATUS_CONTROL, 0);
         chk(rd, r[7:0] & 8'hf8 & ~{2'h0, r[7] & r[8] & r[9] & !r[4], 5'h0});
      end
      // Slave reception of one peer word, LSB first
      // Disable first so a bit count left running in async mode restarts at zero
      apb(1, `RSC_ADDR_STATUS_CONTROL, 32'h0);
      apb(1, `RSC_ADDR_MODE, 32'h1);
      apb(1, `RSC_ADDR_STATUS_CONTROL, 32'hb0);
      go <= 1;
      @(posedge clock);
      go <= 0;
      repeat (60) @(posedge clock);
      chk(rw, r[7:0]);
      apb(0, `RSC_ADDR_STATUS_CONTROL, 0);
      chk(rd, 32'hb0);
      apb(0, 12'h00c, 0);
      chk({rd[30:0], err}, 1);
      results;
   end
endmodule
